// ==== logic/tfmt_top.v ====
`timescale 1ns/1ps
`include "tfmt_defs.vh"

module tfmt_top #(
    parameter ADDR_W = 8
) (
    // Clock and reset
    input  wire              REF_CLK,
    input  wire              RST_N,
    // AXI4-Lite write address
    input  wire              AWVALID,
    output reg               AWREADY,
    input  wire [ADDR_W-1:0] AWADDR,
    // AXI4-Lite write data
    input  wire              WVALID,
    output reg               WREADY,
    input  wire [31:0]       WDATA,
    input  wire [3:0]        WSTRB,
    // AXI4-Lite write response
    output reg               BVALID,
    input  wire              BREADY,
    output reg  [1:0]        BRESP,
    // AXI4-Lite read address
    input  wire              ARVALID,
    output reg               ARREADY,
    input  wire [ADDR_W-1:0] ARADDR,
    // AXI4-Lite read data
    output reg               RVALID,
    input  wire              RREADY,
    output reg  [31:0]       RDATA,
    output reg  [1:0]        RRESP,
    // Measurement results from the converter
    input  wire              MEAS_VALID,
    input  wire [1:0]        MEAS_CHAN,
    input  wire [11:0]       MEAS_TEMP,
    // Status toward the system
    output reg               ALERT_N,
    output wire              MONITOR_EN,
    output wire              RANGE_EXT
);

    // Per-channel indices, channel 0 in the low slice
    localparam [23:0] LO_IDX  = {`IDX_LOCAL_LO, `IDX_REMOTE_LO,
                                 `IDX_CHAN2_LO, `IDX_CHAN1_LO};
    localparam [23:0] HI_IDX  = {`IDX_LOCAL_HI, `IDX_REMOTE_HI,
                                 `IDX_CHAN2_HI, `IDX_CHAN1_HI};
    localparam [23:0] OFS_IDX = {`IDX_LOCAL_OFS, `IDX_REMOTE_OFS,
                                 `IDX_CHAN2_OFS, `IDX_CHAN1_OFS};

    reg                aw_held;
    reg [ADDR_W-1:0]   aw_addr;
    reg                w_held;
    reg [31:0]         w_data;
    reg [3:0]          w_strb;
    reg                next_aw_held;
    reg                next_w_held;
    reg                next_bvalid;
    reg                next_rvalid;
    reg [7:0]          config1;
    reg [7:0]          mask;
    reg [7:0]          status;
    reg                freeze;
    reg [5:0]          seen;
    reg [7:0]          rd_mux;
    reg                rd_ok;
    reg [5:0]          rd_bit;

    wire               wr_fire;
    wire               wr_en;
    wire [5:0]         wr_idx;
    wire               wr_ok;
    wire               rd_fire;
    wire [5:0]         rd_idx;
    wire [7:0]         fmt_hi;
    wire [1:0]         fmt_fr;
    wire [31:0]        lo_v;
    wire [31:0]        hi_v;
    wire [31:0]        ofs_v;
    wire [31:0]        vhi_v;
    wire [7:0]         vfr_v;
    wire [3:0]         oob_set;
    wire [7:0]         set_vec;
    wire [7:0]         clr_vec;

    function is_mapped;
        input [5:0] idx;
        begin
            case (idx)
                `IDX_CONFIG1, `IDX_FRAC_REMOTE, `IDX_FRAC_LOCAL,
                `IDX_CHAN1_VAL, `IDX_CHAN2_VAL, `IDX_REMOTE_VAL,
                `IDX_LOCAL_VAL, `IDX_STATUS, `IDX_MASK,
                `IDX_CHAN1_LO, `IDX_CHAN1_HI, `IDX_CHAN2_LO,
                `IDX_CHAN2_HI, `IDX_REMOTE_LO, `IDX_REMOTE_HI,
                `IDX_LOCAL_LO, `IDX_LOCAL_HI, `IDX_CHAN1_OFS,
                `IDX_CHAN2_OFS, `IDX_REMOTE_OFS, `IDX_LOCAL_OFS:
                    is_mapped = 1'b1;
                default:
                    is_mapped = 1'b0;
            endcase
        end
    endfunction

    assign wr_fire = aw_held && w_held && !BVALID;
    assign wr_idx  = aw_addr[7:2];
    assign wr_en   = wr_fire && w_strb[0];
    assign wr_ok   = is_mapped(wr_idx) && ((aw_addr >> 8) == {ADDR_W{1'b0}});
    assign rd_fire = ARVALID && ARREADY;
    assign rd_idx  = ARADDR[7:2];

    assign MONITOR_EN = config1[`CFG_START_BIT];
    assign RANGE_EXT  = config1[`CFG_RANGE_BIT];

    // Write channel handshake
    always @*
    begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_bvalid  = BVALID;
        if (AWVALID && AWREADY)
            next_aw_held = 1'b1;
        if (WVALID && WREADY)
            next_w_held = 1'b1;
        if (wr_fire)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
        end
        if (BVALID && BREADY)
            next_bvalid = 1'b0;
    end

    always @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= {ADDR_W{1'b0}};
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            AWREADY <= 1'b1;
            WREADY  <= 1'b1;
            BVALID  <= 1'b0;
            BRESP   <= `RESP_OKAY;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            BVALID  <= next_bvalid;
            AWREADY <= !next_aw_held && !next_bvalid;
            WREADY  <= !next_w_held && !next_bvalid;
            if (AWVALID && AWREADY)
                aw_addr <= AWADDR;
            if (WVALID && WREADY)
            begin
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
            if (wr_fire)
                BRESP <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
    end

    // Read data selection
    always @*
    begin
        rd_mux = 8'h00;
        rd_ok  = is_mapped(rd_idx) && ((ARADDR >> 8) == {ADDR_W{1'b0}});
        rd_bit = {rd_idx == `IDX_LOCAL_VAL,  rd_idx == `IDX_REMOTE_VAL,
                  rd_idx == `IDX_CHAN2_VAL,  rd_idx == `IDX_CHAN1_VAL,
                  rd_idx == `IDX_FRAC_LOCAL, rd_idx == `IDX_FRAC_REMOTE};
        case (rd_idx)
            `IDX_CONFIG1:     rd_mux = config1;
            `IDX_FRAC_REMOTE: rd_mux = {4'h0, vfr_v[1:0], vfr_v[5:4]};
            `IDX_FRAC_LOCAL:  rd_mux = {4'h0, vfr_v[3:2], vfr_v[7:6]};
            `IDX_CHAN1_VAL:   rd_mux = vhi_v[7:0];
            `IDX_CHAN2_VAL:   rd_mux = vhi_v[15:8];
            `IDX_REMOTE_VAL:  rd_mux = vhi_v[23:16];
            `IDX_LOCAL_VAL:   rd_mux = vhi_v[31:24];
            `IDX_STATUS:      rd_mux = status;
            `IDX_MASK:        rd_mux = mask;
            `IDX_CHAN1_LO:    rd_mux = lo_v[7:0];
            `IDX_CHAN1_HI:    rd_mux = hi_v[7:0];
            `IDX_CHAN2_LO:    rd_mux = lo_v[15:8];
            `IDX_CHAN2_HI:    rd_mux = hi_v[15:8];
            `IDX_REMOTE_LO:   rd_mux = lo_v[23:16];
            `IDX_REMOTE_HI:   rd_mux = hi_v[23:16];
            `IDX_LOCAL_LO:    rd_mux = lo_v[31:24];
            `IDX_LOCAL_HI:    rd_mux = hi_v[31:24];
            `IDX_CHAN1_OFS:   rd_mux = ofs_v[7:0];
            `IDX_CHAN2_OFS:   rd_mux = ofs_v[15:8];
            `IDX_REMOTE_OFS:  rd_mux = ofs_v[23:16];
            `IDX_LOCAL_OFS:   rd_mux = ofs_v[31:24];
            default:          rd_mux = 8'h00;
        endcase
        if (!rd_ok)
        begin
            rd_mux = 8'h00;
            rd_bit = 6'h00;
        end
    end

    always @*
    begin
        next_rvalid = RVALID;
        if (rd_fire)
            next_rvalid = 1'b1;
        else if (RVALID && RREADY)
            next_rvalid = 1'b0;
    end

    always @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= `RESP_OKAY;
        end
        else
        begin
            RVALID  <= next_rvalid;
            ARREADY <= !next_rvalid;
            if (rd_fire)
            begin
                RDATA <= {24'h00_0000, rd_mux};
                RRESP <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // Configuration and alert mask
    always @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            config1 <= `RST_CONFIG1;
            mask    <= `RST_MASK;
        end
        else
        begin
            if (wr_en && (wr_idx == `IDX_CONFIG1) && wr_ok)
                config1 <= w_data[7:0];
            if (wr_en && (wr_idx == `IDX_MASK) && wr_ok)
                mask <= w_data[7:0];
        end
    end

    // Result freeze across a multi-register read
    always @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            freeze <= 1'b0;
            seen   <= 6'h00;
        end
        else if (rd_fire)
        begin
            if (!freeze && (rd_bit[1:0] != 2'b00))
            begin
                freeze <= 1'b1;
                seen   <= rd_bit;
            end
            else if (freeze)
            begin
                seen <= seen | rd_bit;
                if ((seen | rd_bit) == 6'h3F)
                    freeze <= 1'b0;
            end
        end
    end

    tfmt_format u_format (
        .raw_temp  (MEAS_TEMP),
        .offset    (ofs_v[{MEAS_CHAN, 3'b000} +: 8]),
        .ext_range (config1[`CFG_RANGE_BIT]),
        .high_byte (fmt_hi),
        .frac      (fmt_fr)
    );

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1)
        begin : g_chan
            localparam [31:0] CH_NUM = ch;
            localparam [1:0] CH_ID  = CH_NUM[1:0];
            localparam [7:0] HI_RST = (ch < 2) ? `RST_HI_THERM : `RST_HI_TEMP;
            reg  [7:0] lo;
            reg  [7:0] hi;
            reg  [7:0] ofs;
            reg  [7:0] live_hi;
            reg  [1:0] live_fr;
            reg  [7:0] vis_hi;
            reg  [1:0] vis_fr;
            wire       sel_meas;

            assign sel_meas = MEAS_VALID && (MEAS_CHAN == CH_ID);
            // Compare the formatted byte being stored this cycle against this channel's limits
            assign oob_set[ch] = sel_meas &&
                                 ((fmt_hi > hi) || (fmt_hi < lo));

            always @(posedge REF_CLK or negedge RST_N)
            begin
                if (!RST_N)
                begin
                    lo      <= `RST_LO_LIMIT;
                    hi      <= HI_RST;
                    ofs     <= `RST_OFFSET;
                    live_hi <= `RST_VALUE;
                    live_fr <= 2'h0;
                    vis_hi  <= `RST_VALUE;
                    vis_fr  <= 2'h0;
                end
                else
                begin
                    if (wr_en && (wr_idx == LO_IDX[6*ch +: 6]))
                        lo <= w_data[7:0];
                    if (wr_en && (wr_idx == HI_IDX[6*ch +: 6]))
                        hi <= w_data[7:0];
                    if (wr_en && (wr_idx == OFS_IDX[6*ch +: 6]))
                        ofs <= w_data[7:0];
                    if (sel_meas)
                    begin
                        live_hi <= fmt_hi;
                        live_fr <= fmt_fr;
                    end
                    // Visible copy holds while a freeze is active
                    if (!freeze)
                    begin
                        vis_hi <= live_hi;
                        vis_fr <= live_fr;
                    end
                end
            end

            assign lo_v[8*ch +: 8]  = lo;
            assign hi_v[8*ch +: 8]  = hi;
            assign ofs_v[8*ch +: 8] = ofs;
            assign vhi_v[8*ch +: 8] = vis_hi;
            assign vfr_v[2*ch +: 2] = vis_fr;
        end
    endgenerate

    // Status bit 6 down to bit 3 for channel 0 up to 3
    assign set_vec = {1'b0, oob_set[0], oob_set[1], oob_set[2],
                      oob_set[3], 3'b000};
    assign clr_vec = (rd_fire && rd_ok && (rd_idx == `IDX_STATUS)) ? status : 8'h00;

    always @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            status  <= 8'h00;
            ALERT_N <= 1'b1;
        end
        else
        begin
            // Clear on read; a new violation in the same cycle wins
            status  <= (status & ~clr_vec) | set_vec;
            ALERT_N <= ~|(status & ~mask);
        end
    end

endmodule // tfmt_top

// ==== logic/tfmt_defs.vh ====
`ifndef TFMT_DEFS_VH
`define TFMT_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_CONFIG1     6'h00
`define IDX_FRAC_REMOTE 6'h08
`define IDX_FRAC_LOCAL  6'h09
`define IDX_CHAN1_VAL   6'h0A
`define IDX_CHAN2_VAL   6'h0B
`define IDX_REMOTE_VAL  6'h0D
`define IDX_LOCAL_VAL   6'h0E
`define IDX_STATUS      6'h10
`define IDX_MASK        6'h12
`define IDX_CHAN1_LO    6'h14
`define IDX_CHAN1_HI    6'h15
`define IDX_CHAN2_LO    6'h16
`define IDX_CHAN2_HI    6'h17
`define IDX_REMOTE_LO   6'h1A
`define IDX_REMOTE_HI   6'h1B
`define IDX_LOCAL_LO    6'h1C
`define IDX_LOCAL_HI    6'h1D
`define IDX_CHAN1_OFS   6'h24
`define IDX_CHAN2_OFS   6'h25
`define IDX_REMOTE_OFS  6'h26
`define IDX_LOCAL_OFS   6'h27

// Reset values
`define RST_CONFIG1     8'h00
`define RST_MASK        8'h00
`define RST_LO_LIMIT    8'h00
`define RST_HI_THERM    8'hFF
`define RST_HI_TEMP     8'h7F
`define RST_OFFSET      8'h00
`define RST_VALUE       8'h00

// Field positions
`define CFG_START_BIT   0
`define CFG_RANGE_BIT   7
`define STS_CHAN1_BIT   6

// Formatting constants; shift and tops in quarter degrees, maxima as result codes
`define RANGE_SHIFT_Q   13'h0100
`define BIN_TOP_Q       13'h01FF
`define EXT_TOP_Q       13'h03FF
`define BIN_MAX         8'h7F
`define EXT_MAX         8'hFF
`define FRAC_MAX        2'h3

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== logic/tfmt_format.v ====
`timescale 1ns/1ps
`include "tfmt_defs.vh"

module tfmt_format (
    // Raw reading, two's complement quarter degrees
    input  wire [11:0] raw_temp,
    // Channel correction and coding
    input  wire [7:0]  offset,
    input  wire        ext_range,
    // Formatted result
    output reg  [7:0]  high_byte,
    output reg  [1:0]  frac
);

    wire [12:0] raw_q;
    wire [12:0] ofs_q;
    wire [12:0] sum_q;
    wire [12:0] ext_q;

    assign raw_q = {raw_temp[11], raw_temp};
    // One offset code is one degree, four quarter steps
    assign ofs_q = {{3{offset[7]}}, offset, 2'b00};
    assign sum_q = raw_q + ofs_q;
    assign ext_q = sum_q + `RANGE_SHIFT_Q;

    always @*
    begin
        high_byte = `RST_VALUE;
        frac      = 2'h0;
        if (!ext_range)
        begin
            if (sum_q[12] || (sum_q == 13'h0000))
            begin
                high_byte = `RST_VALUE;
                frac      = 2'h0;
            end
            else if (sum_q > `BIN_TOP_Q)
            begin
                high_byte = `BIN_MAX;
                frac      = `FRAC_MAX;
            end
            else
            begin
                high_byte = sum_q[9:2];
                frac      = sum_q[1:0];
            end
        end
        else
        begin
            if (ext_q[12])
            begin
                high_byte = `RST_VALUE;
                frac      = 2'h0;
            end
            else if (ext_q > `EXT_TOP_Q)
            begin
                high_byte = `EXT_MAX;
                frac      = `FRAC_MAX;
            end
            else
            begin
                high_byte = ext_q[9:2];
                frac      = ext_q[1:0];
            end
        end
    end

endmodule // tfmt_format

// ==== sim/tfmt_checker.sv ====
`timescale 1ns/1ps
module tfmt_checker (
    // Clock and reset
    input wire        REF_CLK,
    input wire        RST_N,
    // Write channels
    input wire        AWVALID,
    input wire        AWREADY,
    input wire        WVALID,
    input wire        WREADY,
    input wire        BVALID,
    input wire        BREADY,
    input wire [1:0]  BRESP,
    // Read channels
    input wire        ARVALID,
    input wire        ARREADY,
    input wire        RVALID,
    input wire        RREADY,
    input wire [31:0] RDATA,
    input wire [1:0]  RRESP,
    // Status
    input wire        MONITOR_EN,
    input wire        RANGE_EXT
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    sequence aw_w_taken;
        AWVALID && AWREADY && WVALID && WREADY;
    endsequence
    sequence read_done;
        RVALID && RREADY;
    endsequence

    write_resp_a: assert property (aw_w_taken |-> ##2 BVALID)
        else $error("write response not on time");
    bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped early");
    rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped early");
    read_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
    rdata_upper_a: assert property (RVALID |-> RDATA[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    busy_refuse_a: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write accepted while busy");
    ready_back_a: assert property (read_done |=> !RVALID && ARREADY)
        else $error("read ready not restored");
    cfg_change_a: assert property ($changed(RANGE_EXT) || $changed(MONITOR_EN) |-> $rose(BVALID))
        else $error("configuration changed without write");
    err_data_a: assert property (RVALID && RRESP == 2'h2 |-> RDATA == 32'h0000_0000)
        else $error("error read returned data");
endmodule // tfmt_checker

bind tfmt_top tfmt_checker tfmt_checker_i (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY),
    .RDATA(RDATA), .RRESP(RRESP), .MONITOR_EN(MONITOR_EN), .RANGE_EXT(RANGE_EXT)
);

// ==== sim/tfmt_top_tb.sv ====
`timescale 1ns/1ps
module tfmt_top_tb;
    logic        REF_CLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, MEAS_VALID;
    logic [7:0]  AWADDR, ARADDR;
    logic [31:0] WDATA;
    logic [3:0]  WSTRB;
    logic [1:0]  MEAS_CHAN;
    logic [11:0] MEAS_TEMP;
    wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, ALERT_N, MONITOR_EN, RANGE_EXT;
    wire  [1:0]  BRESP, RRESP;
    wire  [31:0] RDATA;
    int          fails, compares;
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  res [0:5];
    logic [5:0]  ri  [0:17] = '{6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0D, 6'h0E, 6'h14, 6'h15,
        6'h16, 6'h17, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h24, 6'h25, 6'h26, 6'h27};
    logic [7:0]  rv  [0:17] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
        8'h00, 8'hFF, 8'h00, 8'h7F, 8'h00, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h00};

    tfmt_top #(.ADDR_W(8)) tfmt_top_i (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
        .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY),
        .RDATA(RDATA), .RRESP(RRESP), .MEAS_VALID(MEAS_VALID), .MEAS_CHAN(MEAS_CHAN),
        .MEAS_TEMP(MEAS_TEMP), .ALERT_N(ALERT_N), .MONITOR_EN(MONITOR_EN),
        .RANGE_EXT(RANGE_EXT)
    );

    initial
    begin
        REF_CLK = 1'b0;
        forever #10 REF_CLK = ~REF_CLK;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] v, input logic [3:0] s,
                      output logic [1:0] resp);
        @(posedge REF_CLK);
        AWVALID <= 1'b1;
        AWADDR  <= {idx, 2'b00};
        WVALID  <= 1'b1;
        WDATA   <= {24'h00_0000, v};
        WSTRB   <= s;
        BREADY  <= 1'b1;
        forever
        begin
            @(posedge REF_CLK);
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
            if (BVALID)
            begin
                resp = BRESP;
                BREADY <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [5:0] idx, output logic [31:0] data, output logic [1:0] resp);
        @(posedge REF_CLK);
        ARVALID <= 1'b1;
        ARADDR  <= {idx, 2'b00};
        RREADY  <= 1'b1;
        forever
        begin
            @(posedge REF_CLK);
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
            if (RVALID)
            begin
                data = RDATA;
                resp = RRESP;
                RREADY <= 1'b0;
                break;
            end
        end
    endtask

    task automatic wrc(input logic [5:0] idx, input logic [7:0] v);
        wr(idx, v, 4'h1, r);
        chk(r, 2'h0);
    endtask

    task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
        rd(idx, d, r);
        chk(d, {24'h00_0000, exp});
        chk(r, 2'h0);
    endtask

    task automatic meas(input logic [1:0] ch, input logic [11:0] raw);
        @(posedge REF_CLK);
        MEAS_VALID <= 1'b1;
        MEAS_CHAN  <= ch;
        MEAS_TEMP  <= raw;
        @(posedge REF_CLK);
        MEAS_VALID <= 1'b0;
        repeat (2) @(posedge REF_CLK);
    endtask

    // Extension registers first, then every result, so the freeze always ends
    task automatic fmt(input logic [1:0] ch, input logic [11:0] raw, input logic [7:0] hi,
                       input logic [1:0] fr);
        meas(ch, raw);
        for (int i = 0; i < 6; i++)
        begin
            rd(ri[i], d, r);
            res[i] = d[7:0];
        end
        chk(res[ch + 2], hi);
        chk((res[ch[0]] >> (ch[1] ? 0 : 2)) & 8'h03, fr);
    endtask

    task automatic t_reset;
        for (int i = 0; i < 18; i++) rdc(ri[i], rv[i]);
        chk(RANGE_EXT, 1'b0);
        chk(ALERT_N, 1'b1);
    endtask

    task automatic t_access;
        for (int i = 6; i < 18; i++)
        begin
            wrc(ri[i], 8'h5A);
            rdc(ri[i], 8'h5A);
            wrc(ri[i], rv[i]);
        end
        wrc(6'h0D, 8'hAA);
        rdc(6'h0D, 8'h00);
        wr(6'h15, 8'h11, 4'h0, r);
        rdc(6'h15, 8'hFF);
        wr(6'h3F, 8'h11, 4'h1, r);
        chk(r, 2'h2);
        rd(6'h3F, d, r);
        chk(r, 2'h2);
        chk(d, 32'h0000_0000);
    endtask

    task automatic t_binary;
        fmt(2'd2, 12'h064, 8'h19, 2'h0);
        fmt(2'd2, 12'h067, 8'h19, 2'h3);
        fmt(2'd3, 12'h000, 8'h00, 2'h0);
        fmt(2'd3, 12'hFD8, 8'h00, 2'h0);
        fmt(2'd0, 12'h1FC, 8'h7F, 2'h0);
        fmt(2'd1, 12'h320, 8'h7F, 2'h3);
        fmt(2'd2, 12'h1FF, 8'h7F, 2'h3);
        wrc(6'h26, 8'hFB);
        fmt(2'd2, 12'h064, 8'h14, 2'h0);
        wrc(6'h26, 8'h00);
    endtask

    task automatic t_freeze;
        fmt(2'd2, 12'h064, 8'h19, 2'h0);
        rd(6'h08, d, r);
        meas(2'd2, 12'h0C8);
        rdc(6'h0D, 8'h19);
        rd(6'h09, d, r);
        rd(6'h0A, d, r);
        rd(6'h0B, d, r);
        rd(6'h0E, d, r);
        repeat (2) @(posedge REF_CLK);
        rdc(6'h0D, 8'h32);
    endtask

    task automatic t_limits;
        wrc(6'h00, 8'h01);
        chk(MONITOR_EN, 1'b1);
        rd(6'h10, d, r);
        wrc(6'h15, 8'h30);
        meas(2'd0, 12'h0C8);
        chk(ALERT_N, 1'b0);
        rdc(6'h10, 8'h40);
        repeat (2) @(posedge REF_CLK);
        chk(ALERT_N, 1'b1);
        wrc(6'h1C, 8'h10);
        meas(2'd3, 12'h040);
        rdc(6'h10, 8'h00);
        meas(2'd3, 12'h014);
        rdc(6'h10, 8'h08);
        wrc(6'h12, 8'h08);
        meas(2'd3, 12'h014);
        chk(ALERT_N, 1'b1);
        rdc(6'h10, 8'h08);
    endtask

    task automatic t_ext;
        wrc(6'h00, 8'h81);
        chk(RANGE_EXT, 1'b1);
        fmt(2'd2, 12'hF00, 8'h00, 2'h0);
        fmt(2'd3, 12'h000, 8'h40, 2'h0);
        fmt(2'd0, 12'h2FC, 8'hFF, 2'h0);
        fmt(2'd1, 12'h12D, 8'h8B, 2'h1);
        fmt(2'd2, 12'hEE8, 8'h00, 2'h0);
        fmt(2'd3, 12'h320, 8'hFF, 2'h3);
        wrc(6'h27, 8'h80);
        fmt(2'd3, 12'h190, 8'h24, 2'h0);
        wrc(6'h27, 8'h7F);
        fmt(2'd3, 12'h000, 8'hBF, 2'h0);
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge REF_CLK);
        fails++;
        final_report();
    end

    initial
    begin
        {RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, MEAS_VALID} = 7'h00;
        {AWADDR, ARADDR, WDATA, WSTRB, MEAS_CHAN, MEAS_TEMP} = 66'h0;
        repeat (12) @(posedge REF_CLK);
        RST_N <= 1'b1;
        t_reset();
        t_access();
        t_binary();
        t_freeze();
        t_limits();
        t_ext();
        final_report();
    end
endmodule // tfmt_top_tb
